// >>> hw/ignition_supervision.sv
// Supervision, alarms, sync pulse output and access control behind AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - Over- or under-voltage latches a supply fault and switches ignition off.
// - Switch short/open faults are latched, reported, optionally stop ignition.
// - Closed select input picks the second parameter set, open the first.
// - With a single set configured the select input is ignored.
// - Sixteen independent alarms, each routable to the alarm output.
// - Alarms compare a chosen value above or below a limit.
// - A per-alarm hysteresis separates setting from clearing.
// - The alarm output rests either closed or open, as configured.
// - Sync output idles high; pulse width runs from falling to rising edge.
// - The rising edge lands exactly on the pulse's configured angle.
// - Up to sixteen pulses per cycle, each with own angle and width.
// - Falling edge leads the active edge by the configured width.
// - An invert option makes the sync output active high.
// - Start and run energy are held separately for each set.
// - Four levels, three PIN protected; access control off after reset.
// - Level zero only reads and logs in; level one adds error and denied-flag clear commands.
// - Runtime energy changes need level two or above.
// - Configuration, PIN reset and access enable need level three.
module ignition_supervision (
  input  wire logic                clk,                // 40 MHz clock
  input  wire logic                rst,                // sync reset, high
  input  wire logic                hsel,               // slave select
  input  wire logic [31:0]         haddr,              // byte address
  input  wire logic [1:0]          htrans,             // transfer type
  input  wire logic                hwrite,             // write strobe
  input  wire logic [2:0]          hsize,              // word only
  input  wire logic [31:0]         hwdata,             // write data
  input  wire logic                hready,             // bus ready
  output logic      [31:0]         hrdata,             // read data
  output logic                     hreadyout,          // always ready
  output logic                     hresp,              // always OKAY
  input  wire logic                overVoltRaw,        // supply too high
  input  wire logic                underVoltRaw,       // supply too low
  input  wire logic                schedSelRaw,        // 1 = input closed
  input  wire logic [15:0]         outShortRaw,        // primary short
  input  wire logic [15:0]         outOpenRaw,         // primary open
  input  wire logic [7:0][15:0]    monValues,          // alarm sources
  input  wire logic                startPhase,         // engine starting
  input  wire logic [12:0]         crankAngle,         // tenths of degree
  input  wire logic                angleStep,          // angle updated
  input  wire logic [15:0]         crankRate,          // tenths per 1024us
  output logic                     ignEnable,          // ignition allowed
  output logic                     scheduleB,          // second set used
  output logic      [7:0]          energyLevel,        // selected energy
  output logic                     generalAlarmOutput, // 1 = closed
  output logic                     auxSyncOutput       // sync pulses
);
  ign_sup_pkg::ctrl_t      ctrl;
  ign_sup_pkg::alarm_cfg_t alarmCfg [ign_sup_pkg::ALARM_NUM];
  ign_sup_pkg::sync_cfg_t   syncCfg  [ign_sup_pkg::SYNC_NUM];
  ign_sup_pkg::sync_cfg_t   cur;
  ign_sup_pkg::sync_state_t syncState;
  ign_sup_pkg::sync_state_t next_syncState;

  logic [ign_sup_pkg::PIN_W-1:0] s1, s2, s3, pinState;
  logic [15:0] pin [3];
  logic [31:0] energy;
  logic [31:0] next_hrdata;
  logic [15:0] outShort, outOpen, alarmState, routeMask;
  logic [7:0]  wrAddr;
  logic [1:0]  level, effLevel, needLevel;
  logic [3:0]  syncIdx;
  logic [27:0] prod;
  logic [27:0] leadRaw;
  logic [12:0] lead, fallAngle;
  logic        wrPend, wrOk, accessOn, denied, supplyFault, clrErr;
  logic        syncRun, fallHit, riseHit, useB;

  // Three-stage pin synchroniser; a change is taken once stages 2 and 3 agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      pinState <= '0;
    end else begin
      s1       <= {outOpenRaw, outShortRaw, schedSelRaw, underVoltRaw,
                   overVoltRaw};
      s2       <= s1;
      s3       <= s2;
      pinState <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & pinState);
    end
  end

  // Zero-wait slave: reads are captured in the address phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend    <= 1'b0;
      wrAddr    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend    <= hsel && hready && htrans[1] && hwrite;
      wrAddr    <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        hrdata <= next_hrdata;
      end
    end
  end

  always_comb begin
    next_hrdata = '0;
    unique case (haddr[7:6])
      ign_sup_pkg::BANK_ALARM: next_hrdata = alarmCfg[haddr[5:2]];
      ign_sup_pkg::BANK_SYNC:  next_hrdata = syncCfg[haddr[5:2]];
      ign_sup_pkg::BANK_MISC: begin
        case (haddr[7:0])
          ign_sup_pkg::A_CTRL:   next_hrdata = ctrl;
          ign_sup_pkg::A_STATUS: next_hrdata = {25'h0, accessOn, effLevel,
                                   denied, scheduleB, ignEnable,
                                   supplyFault};
          ign_sup_pkg::A_OUTFLT: next_hrdata = {outOpen, outShort};
          ign_sup_pkg::A_ALARM:  next_hrdata = {16'h0, alarmState};
          ign_sup_pkg::A_ENERGY: next_hrdata = energy;
          ign_sup_pkg::A_ACCESS: next_hrdata = {31'h0, accessOn};
          default:               next_hrdata = '0;
        endcase
      end
      default: next_hrdata = '0;
    endcase
  end

  // Level needed to write each register; PINs and login are write-only.
  always_comb begin
    needLevel = ign_sup_pkg::LVL_MASTER;
    if (wrAddr[7:6] == ign_sup_pkg::BANK_MISC) begin
      case (wrAddr)
        ign_sup_pkg::A_CMD:    needLevel = ign_sup_pkg::LVL_OPER;
        ign_sup_pkg::A_ENERGY: needLevel = ign_sup_pkg::LVL_SERV;
        ign_sup_pkg::A_LOGIN:  needLevel = ign_sup_pkg::LVL_READ;
        default:               needLevel = ign_sup_pkg::LVL_MASTER;
      endcase
    end
  end

  // With access control off every write is allowed.
  assign effLevel = accessOn ? level : ign_sup_pkg::LVL_MASTER;
  assign wrOk     = wrPend && (effLevel >= needLevel);
  assign clrErr   = wrOk && (wrAddr == ign_sup_pkg::A_CMD) &&
                    hwdata[ign_sup_pkg::CMD_CLR_ERR];

  always_ff @(posedge clk) begin
    if (rst) begin
      accessOn <= 1'b0;
      level    <= ign_sup_pkg::LVL_READ;
      pin      <= '{default: ign_sup_pkg::PIN_DEFAULT};
      denied   <= 1'b0;
    end else begin
      if (wrPend && !wrOk) begin
        denied <= 1'b1;
      end else if (wrOk && wrAddr == ign_sup_pkg::A_CMD &&
                   hwdata[ign_sup_pkg::CMD_CLR_DENY]) begin
        denied <= 1'b0;
      end
      if (wrOk && wrAddr == ign_sup_pkg::A_LOGIN) begin
        if (hwdata[15:0] == pin[2]) begin
          level <= ign_sup_pkg::LVL_MASTER;
        end else if (hwdata[15:0] == pin[1]) begin
          level <= ign_sup_pkg::LVL_SERV;
        end else if (hwdata[15:0] == pin[0]) begin
          level <= ign_sup_pkg::LVL_OPER;
        end else begin
          level <= ign_sup_pkg::LVL_READ;
        end
      end
      if (wrOk && wrAddr == ign_sup_pkg::A_ACCESS) begin
        accessOn <= hwdata[ign_sup_pkg::ACC_EN];
        if (hwdata[ign_sup_pkg::ACC_RST_PIN]) begin
          pin <= '{default: ign_sup_pkg::PIN_DEFAULT};
        end
      end
      if (wrOk && wrAddr == ign_sup_pkg::A_PIN1) pin[0] <= hwdata[15:0];
      if (wrOk && wrAddr == ign_sup_pkg::A_PIN2) pin[1] <= hwdata[15:0];
      if (wrOk && wrAddr == ign_sup_pkg::A_PIN3) pin[2] <= hwdata[15:0];
    end
  end

  // Configuration store.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl     <= ign_sup_pkg::CTRL_RESET;
      energy   <= ign_sup_pkg::ENERGY_RESET;
      alarmCfg <= '{default: '0};
      syncCfg  <= '{default: '0};
    end else if (wrOk) begin
      if (wrAddr == ign_sup_pkg::A_CTRL) ctrl <= hwdata;
      if (wrAddr == ign_sup_pkg::A_ENERGY) energy <= hwdata;
      if (wrAddr[7:6] == ign_sup_pkg::BANK_ALARM) begin
        alarmCfg[wrAddr[5:2]] <= hwdata;
      end
      if (wrAddr[7:6] == ign_sup_pkg::BANK_SYNC) begin
        syncCfg[wrAddr[5:2]] <= hwdata;
      end
    end
  end

  // Fault latches: a new fault beats a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      supplyFault <= 1'b0;
      outShort    <= '0;
      outOpen     <= '0;
      ignEnable   <= 1'b0;
    end else begin
      supplyFault <= (supplyFault && !clrErr) ||
                     pinState[ign_sup_pkg::PIN_OVER] ||
                     pinState[ign_sup_pkg::PIN_UNDER];
      outShort <= (outShort & {16{!clrErr}}) |
                  pinState[ign_sup_pkg::PIN_SHORT +: 16];
      outOpen  <= (outOpen & {16{!clrErr}}) |
                  pinState[ign_sup_pkg::PIN_OPEN +: 16];
      ignEnable <= !supplyFault && !(ctrl.stopOnOutFault &&
                   (|outShort || |outOpen));
    end
  end

  a_supply_shutdown: assert property (@(posedge clk) disable iff (rst)
    pinState[ign_sup_pkg::PIN_OVER] |-> ##2 !ignEnable)
    else $error("ignition still enabled after supply fault");

  a_outfault_stop: assert property (@(posedge clk) disable iff (rst)
    (ctrl.stopOnOutFault && |outShort) ##1 $stable(ctrl.stopOnOutFault)
    |-> !ignEnable)
    else $error("ignition not stopped on output fault");

  // Parameter set and energy selection.
  assign useB = ctrl.twoSched &&
                pinState[ign_sup_pkg::PIN_SCHED];

  always_ff @(posedge clk) begin
    if (rst) begin
      scheduleB   <= 1'b0;
      energyLevel <= '0;
    end else begin
      scheduleB <= useB;
      unique case ({useB, startPhase})
        2'b00: energyLevel <= energy[15:8];
        2'b01: energyLevel <= energy[7:0];
        2'b10: energyLevel <= energy[31:24];
        2'b11: energyLevel <= energy[23:16];
      endcase
    end
  end

  a_single_set: assert property (@(posedge clk) disable iff (rst)
    !ctrl.twoSched ##1 !ctrl.twoSched |-> !scheduleB)
    else $error("second set chosen with one set configured");

  a_energy_pick: assert property (@(posedge clk) disable iff (rst)
    (useB && !startPhase) |=> energyLevel == $past(energy[31:24]))
    else $error("wrong run energy for second set");

  // Alarms with hysteresis; clearing uses the widened band.
  for (genvar g = 0; g < ign_sup_pkg::ALARM_NUM; g++) begin : gAlarm
    logic [16:0] val, lim, hi, lo;
    assign val = {1'b0, monValues[alarmCfg[g].src]};
    assign lim = {1'b0, alarmCfg[g].limit};
    assign hi  = lim + {9'h0, alarmCfg[g].hyst};
    assign lo  = (lim > {9'h0, alarmCfg[g].hyst}) ?
                 lim - {9'h0, alarmCfg[g].hyst} : '0;
    assign routeMask[g] = alarmCfg[g].route;
    always_ff @(posedge clk) begin
      if (rst || !alarmCfg[g].enable) begin
        alarmState[g] <= 1'b0;
      end else if (alarmCfg[g].below) begin
        if (val < lim) alarmState[g] <= 1'b1;
        else if (val > hi) alarmState[g] <= 1'b0;
      end else begin
        if (val > lim) alarmState[g] <= 1'b1;
        else if (val < lo) alarmState[g] <= 1'b0;
      end
    end

    // Checked on every alarm in above-limit mode, so whichever one the user configures that way is seen.
    a_alarm_hold: assert property (@(posedge clk) disable iff (rst)
      (alarmState[g] && alarmCfg[g].enable && !alarmCfg[g].below &&
       val >= lo) |=> alarmState[g] || !alarmCfg[g].enable)
      else $error("alarm cleared inside hysteresis band");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      generalAlarmOutput <= 1'b0;
    end else begin
      generalAlarmOutput <= ctrl.alarmNormClosed ^
                            (|(alarmState & routeMask));
    end
  end

  a_out_polarity: assert property (@(posedge clk) disable iff (rst)
    (alarmState & routeMask) == '0 ##1 $stable(ctrl.alarmNormClosed)
    |-> generalAlarmOutput == ctrl.alarmNormClosed)
    else $error("alarm output not at its rest level");

  // Sync output: lead angle = width * rate / 1024, capped below one cycle; the fall angle wraps into the cycle.
  assign cur     = syncCfg[syncIdx];
  assign prod    = 28'(cur.widthUs) * 28'(crankRate);
  assign leadRaw = prod >> ign_sup_pkg::RATE_SHIFT;
  assign lead    = (leadRaw >= 28'(ign_sup_pkg::CYCLE_TENTHS)) ?
                   ign_sup_pkg::CYCLE_TENTHS - 13'h0001 : leadRaw[12:0];
  assign fallAngle = (cur.angle >= lead) ? cur.angle - lead :
                     13'(14'(cur.angle) + 14'(ign_sup_pkg::CYCLE_TENTHS)
                     - 14'(lead));
  assign syncRun = ctrl.syncEnable && (ctrl.pulseCount != '0);
  assign fallHit = angleStep && (crankAngle == fallAngle);
  assign riseHit = angleStep && (crankAngle == cur.angle);

  always_comb begin
    next_syncState = syncState;
    if (!syncRun) begin
      next_syncState = ign_sup_pkg::SYNC_WAIT_FALL;
    end else begin
      unique case (syncState)
        ign_sup_pkg::SYNC_WAIT_FALL:
          if (fallHit) next_syncState = ign_sup_pkg::SYNC_LOW;
        ign_sup_pkg::SYNC_LOW:
          if (riseHit) next_syncState = ign_sup_pkg::SYNC_WAIT_FALL;
      endcase
    end
  end

  // The output is driven from the next state so the edge meets the angle.
  always_ff @(posedge clk) begin
    if (rst) begin
      syncState     <= ign_sup_pkg::SYNC_WAIT_FALL;
      syncIdx       <= '0;
      auxSyncOutput <= 1'b1;
    end else begin
      syncState     <= next_syncState;
      auxSyncOutput <= (next_syncState != ign_sup_pkg::SYNC_LOW) ^
                       ctrl.syncInvert;
      if (!syncRun) begin
        syncIdx <= '0;
      end else if (syncState == ign_sup_pkg::SYNC_LOW && riseHit) begin
        syncIdx <= (5'(syncIdx) + 5'h01 >= ctrl.pulseCount) ?
                   '0 : syncIdx + 4'h1;
      end
    end
  end

  a_sync_rise_angle: assert property (@(posedge clk) disable iff (rst)
    ($past(syncState) == ign_sup_pkg::SYNC_LOW &&
     syncState == ign_sup_pkg::SYNC_WAIT_FALL && $past(syncRun)) |->
    $past(crankAngle) == $past(cur.angle) && $past(angleStep))
    else $error("sync active edge off its angle");

  a_sync_idle_level: assert property (@(posedge clk) disable iff (rst)
    (syncState == ign_sup_pkg::SYNC_WAIT_FALL && !fallHit) |=>
    auxSyncOutput == !$past(ctrl.syncInvert))
    else $error("sync output not at idle level");

  a_sync_fall_lead: assert property (@(posedge clk) disable iff (rst)
    ($past(syncState) == ign_sup_pkg::SYNC_WAIT_FALL &&
     syncState == ign_sup_pkg::SYNC_LOW) |->
    $past(crankAngle) == $past(fallAngle))
    else $error("sync falling edge not at lead angle");

  a_denied_write: assert property (@(posedge clk) disable iff (rst)
    (wrPend && accessOn && level == ign_sup_pkg::LVL_READ &&
     wrAddr == ign_sup_pkg::A_ENERGY) |=> $stable(energy) && denied)
    else $error("read-only level changed energy");
endmodule

// >>> pkg/ign_sup_pkg.sv
// Shared constants, register map and carrier types of the supervision block.
package ign_sup_pkg;
  localparam int ALARM_NUM  = 16;
  localparam int SYNC_NUM   = 16;
  localparam int SRC_NUM    = 8;
  localparam int OUT_NUM    = 16;
  localparam int RATE_SHIFT = 10;

  // Byte offsets of the miscellaneous bank.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_OUTFLT = 8'h08;
  localparam logic [7:0] A_ALARM  = 8'h0c;
  localparam logic [7:0] A_CMD    = 8'h10;
  localparam logic [7:0] A_ENERGY = 8'h14;
  localparam logic [7:0] A_LOGIN  = 8'h18;
  localparam logic [7:0] A_ACCESS = 8'h1c;
  localparam logic [7:0] A_PIN1   = 8'h20;
  localparam logic [7:0] A_PIN2   = 8'h24;
  localparam logic [7:0] A_PIN3   = 8'h28;

  // Bank select is address bits 7:6, word index bits 5:2.
  localparam logic [1:0] BANK_MISC  = 2'h0;
  localparam logic [1:0] BANK_ALARM = 2'h1;
  localparam logic [1:0] BANK_SYNC  = 2'h2;

  localparam logic [1:0] LVL_READ   = 2'h0;
  localparam logic [1:0] LVL_OPER   = 2'h1;
  localparam logic [1:0] LVL_SERV   = 2'h2;
  localparam logic [1:0] LVL_MASTER = 2'h3;

  localparam int CMD_CLR_ERR  = 0;
  localparam int CMD_CLR_DENY = 1;
  localparam int ACC_EN       = 0;
  localparam int ACC_RST_PIN  = 1;

  localparam logic [15:0] PIN_DEFAULT  = 16'h0000;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] ENERGY_RESET = 32'h0000_0000;
  // One engine cycle is 720 degrees, counted in tenths.
  localparam logic [12:0] CYCLE_TENTHS = 13'h1c20;

  // Synchronised pin vector layout.
  localparam int PIN_OVER  = 0;
  localparam int PIN_UNDER = 1;
  localparam int PIN_SCHED = 2;
  localparam int PIN_SHORT = 3;
  localparam int PIN_OPEN  = 19;
  localparam int PIN_W     = 35;

  typedef struct packed {
    logic [21:0] rsvd;
    logic [4:0]  pulseCount;
    logic        syncEnable;
    logic        syncInvert;
    logic        alarmNormClosed;
    logic        stopOnOutFault;
    logic        twoSched;
  } ctrl_t;

  typedef struct packed {
    logic [1:0]  rsvd;
    logic        route;
    logic        enable;
    logic        below;
    logic [2:0]  src;
    logic [7:0]  hyst;
    logic [15:0] limit;
  } alarm_cfg_t;

  typedef struct packed {
    logic [3:0]  rsvdHi;
    logic [11:0] widthUs;
    logic [2:0]  rsvdLo;
    logic [12:0] angle;
  } sync_cfg_t;

  typedef enum logic {SYNC_WAIT_FALL, SYNC_LOW} sync_state_t;
endpackage

// >>> verification/sync_receiver.sv
// Model of the receiving control unit that decodes the sync pulse train.
`timescale 1ns/1ps
module sync_receiver #(
  parameter int LONG_MIN = 18  // shortest width, in clocks, taken as long
) (
  input  wire logic clk,        // system clock
  input  wire logic rst,        // sync reset, high
  input  wire logic syncLine,   // sync pulse line
  input  wire logic activeHigh, // polarity the sender uses
  output int        lastWidth,  // width of the last pulse in clocks
  output int        cylinder    // cylinder given to the last active edge
);
  int run;

  // A polarity change while idle can look like a short pulse; the next
  // long pulse puts the numbering back on cylinder one.
  always_ff @(posedge clk) begin
    if (rst) begin
      run       <= 0;
      lastWidth <= 0;
      cylinder  <= 0;
    end else if (syncLine == activeHigh) begin
      run <= run + 1;
    end else if (run != 0) begin
      lastWidth <= run;
      cylinder  <= (run >= LONG_MIN) ? 1 : cylinder + 1;
      run       <= 0;
    end
  end
endmodule

// >>> verification/test_ignition_supervision_sync_output.sv
// Self-checking bench for the supervision and sync output block.
`timescale 1ns/1ps
module test_ignition_supervision_sync_output;
  logic             clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic      [31:0] haddr = '0, hwdata = '0, hrdata, q, e;
  logic      [31:0] rnd = 32'h3d73;
  logic      [1:0]  htrans = 2'h0;
  logic      [2:0]  hsize = 3'h2;
  logic             hreadyout, hresp, ignEnable, scheduleB, alarmOut, sync;
  logic             overVolt = 1'h0, underVolt = 1'h0, schedSel = 1'h0;
  logic             startPhase = 1'h0, angleStep = 1'h0, activeHigh = 1'h0;
  logic      [15:0] outShort = '0, outOpen = '0, crankRate = 16'h0400;
  logic      [15:0] p1;
  logic [7:0][15:0] monValues = '0;
  logic      [12:0] crankAngle = '0;
  logic      [7:0]  energyLevel;
  logic      [31:0] mdl [logic [7:0]];
  logic             denied = 1'h0, act;
  int               n_fail = 0, n_tests = 0, lvl = 3, cyc = 0;
  int               k, j, f0, f1, rxWidth, rxCyl;
  logic      [15:0] av [2][3] = '{'{16'h0065, 16'h005f, 16'h0059},
                                  '{16'h0063, 16'h0069, 16'h006f}};

  ignition_supervision dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .overVoltRaw(overVolt),
    .underVoltRaw(underVolt), .schedSelRaw(schedSel),
    .outShortRaw(outShort), .outOpenRaw(outOpen), .monValues(monValues),
    .startPhase(startPhase), .crankAngle(crankAngle),
    .angleStep(angleStep), .crankRate(crankRate), .ignEnable(ignEnable),
    .scheduleB(scheduleB), .energyLevel(energyLevel),
    .generalAlarmOutput(alarmOut), .auxSyncOutput(sync));

  sync_receiver #(.LONG_MIN(18)) rx (.clk(clk), .rst(rst),
    .syncLine(sync), .activeHigh(activeHigh), .lastWidth(rxWidth),
    .cylinder(rxCyl));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The bus stays selected between transfers; only htrans marks a request.
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int need;
    logic [31:0] r;
    need = a == ign_sup_pkg::A_LOGIN ? 0 : a == ign_sup_pkg::A_CMD ? 1 :
           a == ign_sup_pkg::A_ENERGY ? 2 : 3;
    bus(a, 1'h1, d, r);
    if (lvl >= need) begin
      mdl[a] = d;
      if (a == ign_sup_pkg::A_CMD && d[1]) denied = 1'h0;
    end else begin
      denied = 1'h1;
    end
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] x);
    bus(a, 1'h0, '0, q);
    chk(nm, q, x);
  endtask

  initial begin
    mdl[ign_sup_pkg::A_CTRL]   = ign_sup_pkg::CTRL_RESET;
    mdl[ign_sup_pkg::A_ENERGY] = ign_sup_pkg::ENERGY_RESET;
    tick(12);
    chk("ign in reset", ignEnable, 1'h0);
    chk("sync in reset", sync, 1'h1);
    chk("bus idle", {hreadyout, hresp}, 2'h2);
    rst <= 1'h0;
    tick(8);
    chk("ign", ignEnable, 1'h1);
    rd("ctrl", ign_sup_pkg::A_CTRL, mdl[ign_sup_pkg::A_CTRL]);
    rd("access", ign_sup_pkg::A_ACCESS, '0);
    rd("unmapped", 8'h3c, '0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      overVolt  <= i == 0;
      underVolt <= i == 1;
      tick(8);
      overVolt  <= 1'h0;
      underVolt <= 1'h0;
      tick(8);
      chk("ign", ignEnable, 1'h0);
      rd("status", ign_sup_pkg::A_STATUS, 32'h31);
      wr(ign_sup_pkg::A_CMD, 32'h1);
      tick(4);
      chk("ign", ignEnable, 1'h1);
    end
    wr(ign_sup_pkg::A_CTRL, 32'h2);
    rnd = lfsr(rnd);
    k = rnd[3:0];
    j = rnd[7:4];
    e = '0;
    e[k] = 1'h1;
    e[16 + j] = 1'h1;
    @(posedge clk);
    outShort[k] <= 1'h1;
    outOpen[j]  <= 1'h1;
    tick(8);
    outShort <= '0;
    outOpen  <= '0;
    tick(8);
    chk("ign", ignEnable, 1'h0);
    rd("outflt", ign_sup_pkg::A_OUTFLT, e);
    wr(ign_sup_pkg::A_CMD, 32'h1);
    tick(4);
    chk("ign", ignEnable, 1'h1);
    for (int i = 0; i < 3; i++) begin
      wr(ign_sup_pkg::A_CTRL, {31'h0, i != 0});
      schedSel <= i != 2;
      tick(8);
      chk("scheduleB", scheduleB, i == 1);
    end
    rnd = lfsr(rnd);
    wr(ign_sup_pkg::A_ENERGY, rnd);
    rd("energy", ign_sup_pkg::A_ENERGY, mdl[ign_sup_pkg::A_ENERGY]);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      schedSel   <= i / 2;
      startPhase <= i % 2 == 0;
      tick(8);
      chk("energy", energyLevel, rnd[8 * i +: 8]);
    end
    for (int m = 0; m < 8; m++) begin
      rnd = lfsr(rnd);
      monValues[m] <= rnd[15:0];
    end
    k = rnd[7:4];
    for (int b = 0; b < 2; b++) begin
      wr(8'(8'h40 + 4 * k), {4'h3, b[0], 3'h3, 8'h0a, 16'h0064});
      for (int s = 0; s < 3; s++) begin
        @(posedge clk);
        monValues[3] <= av[b][s];
        tick(4);
        e = '0;
        e[k] = s < 2;
        rd("alarm", ign_sup_pkg::A_ALARM, e);
        chk("alarm out", alarmOut, s < 2);
      end
    end
    wr(ign_sup_pkg::A_CTRL, 32'h4);
    tick(3);
    chk("alarm out rest", alarmOut, 1'h1);
    monValues[3] <= 16'h0000;
    tick(4);
    chk("alarm out set", alarmOut, 1'h0);
    wr(8'h80, {4'h0, 12'h014, 3'h0, 13'h00c8});
    wr(8'h84, {4'h0, 12'h00a, 3'h0, 13'h0190});
    for (int v = 0; v < 2; v++) begin
      crankRate  <= v ? 16'h0600 : 16'h0400;
      activeHigh <= v[0];
      wr(ign_sup_pkg::A_CTRL, 32'h50 | (v << 3));
      tick(4);
      f0 = 200 - ((20 * (v ? 1536 : 1024)) >> 10);
      f1 = 400 - ((10 * (v ? 1536 : 1024)) >> 10);
      for (int a = 0; a < 450; a++) begin
        @(posedge clk);
        crankAngle <= 13'(a);
        angleStep  <= 1'h1;
        #1;
        act = (a > f0 && a <= 200) || (a > f1 && a <= 400);
        if (a > 0) chk("sync", sync, act == v[0]);
      end
      angleStep <= 1'h0;
      tick(2);
      chk("rx width", 32'(rxWidth), 32'(400 - f1));
      chk("rx cylinder", 32'(rxCyl), 32'h2);
    end
    rnd = lfsr(rnd);
    p1 = rnd[15:0] | 16'h0001;
    wr(ign_sup_pkg::A_PIN1, {16'h0, p1});
    wr(ign_sup_pkg::A_PIN2, {16'h0, p1 ^ 16'h8000});
    wr(ign_sup_pkg::A_ACCESS, 32'h1);
    for (int l = 0; l < 3; l++) begin
      lvl = l;
      wr(ign_sup_pkg::A_LOGIN, {16'h0, l == 0 ? p1 ^ 16'h0002 :
                                l == 1 ? p1 : p1 ^ 16'h8000});
      wr(ign_sup_pkg::A_CMD, 32'h2);
      wr(ign_sup_pkg::A_ENERGY, ~rnd);
      wr(ign_sup_pkg::A_CTRL, 32'h0);
      e = mdl[ign_sup_pkg::A_ENERGY];
      rd("energy", ign_sup_pkg::A_ENERGY, e);
      rd("ctrl", ign_sup_pkg::A_CTRL, mdl[ign_sup_pkg::A_CTRL]);
      bus(ign_sup_pkg::A_STATUS, 1'h0, '0, q);
      chk("level", q[6:3], {1'h1, 2'(l), denied});
    end
    lvl = 3;
    wr(ign_sup_pkg::A_LOGIN, 32'h0);
    wr(ign_sup_pkg::A_ACCESS, 32'h2);
    rd("access", ign_sup_pkg::A_ACCESS, '0);
    tally_and_finish();
  end
endmodule
